//--- verilog/sbus_pkg.sv
package sbus_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int CODE_W  = 10;
  localparam int TYPE_W  = 3;
  localparam int BYTE_W  = 8;
  localparam int ADDR_W  = 5;
  localparam int CNT_W   = 8;
  localparam int HDR_PRE = 24;

  // ----------------------------------------
  // header layout, after the start bit
  // ----------------------------------------
  localparam int POS_S     = 12;
  localparam int POS_R     = 2;
  localparam int POS_ARB   = 1;
  localparam logic [CNT_W-1:0] HDR_BITS = 8'h1A;
  localparam logic [CNT_W-1:0] HDR_LAST = HDR_BITS - 8'h02;
  localparam logic [CNT_W-1:0] SUB_LAST = 8'h02;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [CODE_W-1:0] CODE_DUMMY   = 10'h3FF;
  localparam logic [TYPE_W-1:0] FT_NONE      = 3'h0;
  localparam logic [TYPE_W-1:0] FT_CANCEL    = 3'h7;
  localparam logic [TYPE_W-1:0] STS_S_SIDE   = 3'h2;
  localparam logic [TYPE_W-1:0] STS_R_SIDE   = 3'h1;
  localparam logic [TYPE_W-1:0] STS_SIZE_ERR = 3'h6;
  localparam logic [TYPE_W-1:0] STS_TOO_LONG = 3'h5;
  localparam logic [CNT_W:0]    BITS_BYTE    = 9'h008;

  // ----------------------------------------
  // jam run length in bit times
  // ----------------------------------------
  localparam logic [CNT_W-1:0] JAM_RUN_BITS = 8'h10;
  localparam logic [CNT_W-1:0] JAM_LAST     = JAM_RUN_BITS - 8'h01;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FF_SIMPLE = 2'h0,
    FF_SEMA   = 2'h1,
    FF_TOKEN  = 2'h2
  } ff_mode_t;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_HDR    = 8'h02,
    S_TYPE   = 8'h04,
    S_DATA   = 8'h08,
    S_STAT   = 8'h10,
    S_JAM    = 8'h20,
    S_JAMRUN = 8'h40,
    S_RESYNC = 8'h80
  } frame_state_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic sel_match(input logic [CODE_W-1:0] field, input logic [CODE_W-1:0] own);
    sel_match = (field == own) && (own != CODE_DUMMY);
  endfunction

  function automatic logic msb_bit(input logic [TYPE_W-1:0] v, input logic [1:0] k);
    case (k)
      2'h0:    msb_bit = v[2];
      2'h1:    msb_bit = v[1];
      default: msb_bit = v[0];
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] data_last(input logic [TYPE_W-1:0] code);
    logic [CNT_W:0] n;
    n = BITS_BYTE << (code - 3'h1);
    data_last = n[CNT_W-1:0] - 8'h01;
  endfunction

endpackage

//--- verilog/header_capture.sv
`timescale 1ns/1ps
module header_capture (
  // clock and reset
  input  logic                          clk,
  input  logic                          reset_n,
  // shift input
  input  logic                          shift_en,
  input  logic                          bit_in,
  // held bits
  output logic [sbus_pkg::HDR_PRE-1:0]  held
);
  import sbus_pkg::*;

  // ----------------------------------------
  // header shift register
  // ----------------------------------------
  logic [HDR_PRE-1:0] held_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_ff <= '0;
    end else if (shift_en) begin
      held_ff <= {held_ff[HDR_PRE-2:0], bit_in};
    end
  end

  assign held = held_ff;

endmodule

//--- verilog/byte_store.sv
`timescale 1ns/1ps
module byte_store (
  // clock
  input  logic                         clk,
  // write port
  input  logic                         wr_en,
  input  logic [sbus_pkg::ADDR_W-1:0]  wr_addr,
  input  logic [sbus_pkg::BYTE_W-1:0]  wr_data,
  // read port
  input  logic [sbus_pkg::ADDR_W-1:0]  rd_addr,
  output logic [sbus_pkg::BYTE_W-1:0]  rd_data
);
  import sbus_pkg::*;

  // ----------------------------------------
  // byte array
  // ----------------------------------------
  logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

//--- verilog/serial_bus_frame_responder.sv
`timescale 1ns/1ps
// Contract
// - reset frame R match clears, sends 001
// - simple flip-flop group leaves type undriven
// - type 000 ends after status; signal
// - own monitor reports captured status value
// - semaphore set while set: drive 111
// - semaphore clear: set, status 010
// - reset clears unless send field also matches; set wins
// - token cancels redundant set or clear
// - token: 010 plus 001 gives 011
// - sender drives size, abandons on 111
// - data length follows announced code
// - size mismatch: sender drives 110
// - sender 10 unless high bit one
// - receiver too short: drives 101
// - receiver 01 unless high bit one
// - success status 011 is reported
// - not ready: cancel with 111
// - on 111 free bus, flag failure
// - jam bit zero; sync loss drives ones
// - jammed frame changes nothing
// - own jammed frame resent after resync
// - header is 26 bits, fixed fields
// - frame type code table
// - all ones code never matches
module serial_bus_frame_responder (
  // clock and reset
  input  logic                         clk,
  input  logic                         reset_n,
  // serial line
  input  logic                         shared_serial_line_n,
  output logic                         line_out,
  output logic                         line_oe,
  input  logic                         bit_tick,
  input  logic                         sync_err,
  // group setup
  input  logic [sbus_pkg::CODE_W-1:0]  own_code,
  input  logic                         has_ff,
  input  sbus_pkg::ff_mode_t           ff_mode,
  input  logic                         has_sender,
  input  logic                         has_receiver,
  // flip-flop
  output logic                         ff_state,
  // data sender
  input  logic                         tx_ready,
  input  logic [sbus_pkg::TYPE_W-1:0]  tx_code,
  input  logic                         tx_wr,
  input  logic [sbus_pkg::ADDR_W-1:0]  tx_addr,
  input  logic [sbus_pkg::BYTE_W-1:0]  tx_wdata,
  output logic                         tx_sent,
  // data receiver
  input  logic [sbus_pkg::TYPE_W-1:0]  rx_max_code,
  input  logic                         rx_release,
  input  logic [sbus_pkg::ADDR_W-1:0]  rx_addr,
  output logic [sbus_pkg::BYTE_W-1:0]  rx_rdata,
  output logic                         rx_full,
  output logic [sbus_pkg::TYPE_W-1:0]  rx_len,
  output logic                         rx_done,
  // frame monitor
  input  logic                         own_frame,
  output logic                         frame_busy,
  output logic                         frame_done,
  output logic [sbus_pkg::TYPE_W-1:0]  status_val,
  output logic                         status_stb,
  output logic                         cancel_stb,
  output logic                         resend_req
);
  import sbus_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  frame_state_t      state_ff;
  frame_state_t      nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic [HDR_PRE-1:0] hdr_hold;
  logic [HDR_PRE:0]  full_hdr;
  logic [CODE_W-1:0] s_field;
  logic [CODE_W-1:0] r_field;
  logic [TYPE_W-1:0] type_ff;
  logic [TYPE_W-1:0] nxt_type;
  logic [TYPE_W-1:0] ftype;
  logic [TYPE_W-1:0] stat_ff;
  logic [TYPE_W-1:0] stat_code;
  logic [BYTE_W-1:0] rx_sh_ff;
  logic [BYTE_W-1:0] tx_byte;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] rx_rd;
  logic              smp, hdr_end, jam_tick, jam_ok, s_m, r_m, cancel_now;
  logic              s_hit_ff, r_hit_ff, snd_ff, rcv_ff, arb_ff, cancel_ff, abandon_ff;
  logic              nxt_s_hit, nxt_r_hit, nxt_snd, nxt_rcv, nxt_cancel, nxt_abandon;
  logic              stat_hi_ff, nxt_hi, mism, too_long, type_none, type_data;
  logic              drive_ff, nxt_drive, arb_loss, rx_we, ff_q, rx_full_ff, pend_ff, resync_done;

  // ----------------------------------------
  // line sampling and drive
  // ----------------------------------------
  assign smp      = ~shared_serial_line_n;
  assign line_out = 1'b0;
  assign line_oe  = drive_ff;

  header_capture u_hdr (
    .clk      (clk),
    .reset_n  (reset_n),
    .shift_en (bit_tick & (state_ff == S_HDR)),
    .bit_in   (smp),
    .held     (hdr_hold)
  );

  assign hdr_end  = bit_tick & (state_ff == S_HDR) & (cnt_ff == HDR_LAST);
  assign full_hdr = {hdr_hold, smp};
  assign s_field  = full_hdr[POS_S +: CODE_W];
  assign r_field  = full_hdr[POS_R +: CODE_W];
  assign s_m      = sel_match(s_field, own_code);
  assign r_m      = sel_match(r_field, own_code);
  assign jam_tick = bit_tick & (state_ff == S_JAM);
  assign jam_ok   = jam_tick & ~smp & ~sync_err;
  assign ftype    = {type_ff[1:0], smp};
  assign nxt_type = (bit_tick & (state_ff == S_TYPE)) ? ftype : type_ff;

  // ----------------------------------------
  // frame type decode
  // ----------------------------------------
  assign type_none = (nxt_type == FT_NONE);
  assign type_data = ~type_none & (nxt_type != FT_CANCEL);
  assign mism      = (nxt_type != tx_code);
  assign too_long  = (nxt_type > rx_max_code);

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (bit_tick) begin
      nxt_cnt = cnt_ff + 8'h01;
      case (state_ff)
        S_IDLE: begin
          if (smp) begin
            nxt_state = S_HDR;
            nxt_cnt   = CNT_ZERO;
          end else begin
            nxt_cnt = CNT_ZERO;
          end
        end
        S_HDR: begin
          if (cnt_ff == HDR_LAST) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = smp ? S_TYPE : S_IDLE;
          end
        end
        S_TYPE: begin
          if (cnt_ff == SUB_LAST) begin
            nxt_cnt = CNT_ZERO;
            if (ftype == FT_CANCEL) begin
              nxt_state = S_JAM;
            end else if (ftype == FT_NONE) begin
              nxt_state = S_STAT;
            end else begin
              nxt_state = S_DATA;
            end
          end
        end
        S_DATA: begin
          if (cnt_ff == data_last(type_ff)) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = S_STAT;
          end
        end
        S_STAT: begin
          if (cnt_ff == SUB_LAST) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = S_JAM;
          end
        end
        S_JAM: begin
          nxt_cnt   = CNT_ZERO;
          nxt_state = smp ? S_RESYNC : S_IDLE;
        end
        S_JAMRUN: begin
          if (cnt_ff == JAM_LAST) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = S_RESYNC;
          end
        end
        S_RESYNC: begin
          if (smp) begin
            nxt_cnt = CNT_ZERO;
          end else if (cnt_ff == JAM_LAST) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = S_IDLE;
          end
        end
        default: begin
          nxt_state = S_IDLE;
          nxt_cnt   = CNT_ZERO;
        end
      endcase
    end
    if (sync_err) begin
      nxt_state = S_JAMRUN;
      nxt_cnt   = CNT_ZERO;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_IDLE;
      cnt_ff   <= CNT_ZERO;
      drive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      drive_ff <= nxt_drive;
    end
  end

  // ----------------------------------------
  // header decisions
  // ----------------------------------------
  assign cancel_now = (has_ff & s_m & ff_q & (ff_mode != FF_SIMPLE))
                    | (has_ff & r_m & ~ff_q & (ff_mode == FF_TOKEN))
                    | (has_sender & s_m & ~tx_ready)
                    | (has_receiver & r_m & rx_full_ff);

  assign nxt_s_hit   = hdr_end ? (has_ff & s_m) : s_hit_ff;
  assign nxt_r_hit   = hdr_end ? (has_ff & r_m) : r_hit_ff;
  assign nxt_snd     = hdr_end ? (has_sender & s_m) : snd_ff;
  assign nxt_rcv     = hdr_end ? (has_receiver & r_m) : rcv_ff;
  assign nxt_cancel  = hdr_end ? cancel_now : cancel_ff;
  assign arb_loss    = bit_tick & (state_ff == S_DATA) & snd_ff & arb_ff & ~drive_ff & smp;
  assign nxt_abandon = hdr_end ? 1'b0 : (abandon_ff | arb_loss);
  assign nxt_hi      = (bit_tick & (state_ff == S_STAT) & (cnt_ff == CNT_ZERO)) ? smp : stat_hi_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_hit_ff   <= 1'b0;
      r_hit_ff   <= 1'b0;
      snd_ff     <= 1'b0;
      rcv_ff     <= 1'b0;
      cancel_ff  <= 1'b0;
      abandon_ff <= 1'b0;
      arb_ff     <= 1'b0;
    end else begin
      s_hit_ff   <= nxt_s_hit;
      r_hit_ff   <= nxt_r_hit;
      snd_ff     <= nxt_snd;
      rcv_ff     <= nxt_rcv;
      cancel_ff  <= nxt_cancel;
      abandon_ff <= nxt_abandon;
      arb_ff     <= hdr_end ? full_hdr[POS_ARB] : arb_ff;
    end
  end

  // ----------------------------------------
  // slot drive
  // ----------------------------------------
  always_comb begin
    stat_code = FT_NONE;
    if (type_none) begin
      if (nxt_s_hit) stat_code = stat_code | STS_S_SIDE;
      if (nxt_r_hit) stat_code = stat_code | STS_R_SIDE;
    end else if (type_data) begin
      if (nxt_snd) begin
        if (mism) stat_code = stat_code | STS_SIZE_ERR;
        else if (!nxt_hi) stat_code = stat_code | STS_S_SIDE;
      end
      if (nxt_rcv) begin
        if (too_long) stat_code = stat_code | STS_TOO_LONG;
        else if (!nxt_hi) stat_code = stat_code | STS_R_SIDE;
      end
    end
  end

  always_comb begin
    nxt_drive = drive_ff;
    if (bit_tick | sync_err) begin
      case (nxt_state)
        S_TYPE:   nxt_drive = nxt_cancel | (nxt_snd & msb_bit(tx_code, nxt_cnt[1:0]));
        S_DATA:   nxt_drive = nxt_snd & ~nxt_abandon & tx_byte[3'h7 - nxt_cnt[2:0]];
        S_STAT:   nxt_drive = msb_bit(stat_code, nxt_cnt[1:0]);
        S_JAMRUN: nxt_drive = 1'b1;
        default:  nxt_drive = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // subframe capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      type_ff    <= FT_NONE;
      stat_ff    <= FT_NONE;
      stat_hi_ff <= 1'b0;
      rx_sh_ff   <= '0;
    end else begin
      type_ff    <= nxt_type;
      stat_hi_ff <= nxt_hi;
      if (bit_tick && state_ff == S_STAT) stat_ff <= {stat_ff[1:0], smp};
      if (bit_tick && state_ff == S_DATA) rx_sh_ff <= rx_byte;
    end
  end

  // ----------------------------------------
  // data buffers
  // ----------------------------------------
  assign rx_byte = {rx_sh_ff[BYTE_W-2:0], smp};
  assign rx_we   = bit_tick & (state_ff == S_DATA) & rcv_ff & ~too_long & (cnt_ff[2:0] == 3'h7);

  byte_store u_tx (
    .clk     (clk),
    .wr_en   (tx_wr),
    .wr_addr (tx_addr),
    .wr_data (tx_wdata),
    .rd_addr (nxt_cnt[CNT_W-1:3]),
    .rd_data (tx_byte)
  );

  byte_store u_rx (
    .clk     (clk),
    .wr_en   (rx_we),
    .wr_addr (cnt_ff[CNT_W-1:3]),
    .wr_data (rx_byte),
    .rd_addr (rx_addr),
    .rd_data (rx_rd)
  );

  // ----------------------------------------
  // flip-flop, commit on clean jam bit only
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ff_q <= 1'b0;
    end else if (jam_ok && type_none) begin
      if (s_hit_ff) ff_q <= 1'b1;
      else if (r_hit_ff) ff_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // sender and receiver results
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sent    <= 1'b0;
      rx_done    <= 1'b0;
      rx_full_ff <= 1'b0;
      rx_len     <= FT_NONE;
      rx_rdata   <= '0;
    end else begin
      rx_rdata <= rx_rd;
      tx_sent  <= jam_ok & type_data & snd_ff & ~mism;
      rx_done  <= jam_ok & type_data & rcv_ff & ~too_long;
      if (jam_ok && type_data && rcv_ff && !too_long) begin
        rx_full_ff <= 1'b1;
        rx_len     <= type_ff;
      end else if (rx_release) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // frame monitor
  // ----------------------------------------
  assign resync_done = bit_tick & (state_ff == S_RESYNC) & ~smp & (cnt_ff == JAM_LAST) & ~sync_err;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_done <= 1'b0;
      status_stb <= 1'b0;
      cancel_stb <= 1'b0;
      status_val <= FT_NONE;
      resend_req <= 1'b0;
      pend_ff    <= 1'b0;
    end else begin
      frame_done <= jam_ok | resync_done;
      status_stb <= jam_ok & own_frame & (type_ff != FT_CANCEL);
      cancel_stb <= jam_ok & own_frame & (type_ff == FT_CANCEL);
      if (jam_ok && own_frame && type_ff != FT_CANCEL) status_val <= stat_ff;
      resend_req <= resync_done & pend_ff;
      if (own_frame && ((jam_tick && smp) || sync_err)) pend_ff <= 1'b1;
      else if (resync_done) pend_ff <= 1'b0;
    end
  end

  assign ff_state   = ff_q;
  assign rx_full    = rx_full_ff;
  assign frame_busy = (state_ff != S_IDLE);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ff_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (jam_ok && r_hit_ff && !s_hit_ff && type_none) |=> !ff_state) else $error("flip-flop not cleared");
  type_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == S_TYPE && !cancel_ff && !snd_ff) |-> !line_oe) else $error("type slot driven");
  cancel_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == S_TYPE && cancel_ff) |-> line_oe) else $error("cancel not driven");
  frame_free_a: assert property (@(posedge clk) disable iff (!reset_n)
    jam_ok |=> frame_done) else $error("bus free not signalled");
  sema_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (jam_ok && s_hit_ff && type_none) |=> ff_state) else $error("flip-flop not set");
  status_rep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (jam_ok && own_frame && type_ff != FT_CANCEL) |=> (status_stb && status_val == $past(stat_ff)))
    else $error("status not reported");
  jam_run_a: assert property (@(posedge clk) disable iff (!reset_n)
    sync_err |=> line_oe [*8]) else $error("jam run missing");
  jam_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
    (jam_tick && smp) |=> ($stable(ff_state) && !rx_done && !tx_sent)) else $error("jammed frame used");
  dummy_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    (hdr_end && s_field == CODE_DUMMY) |=> (!s_hit_ff && !snd_ff)) else $error("dummy code matched");
  cancel_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    (bit_tick && state_ff == S_TYPE && cnt_ff == SUB_LAST && ftype == FT_CANCEL && !sync_err)
    |=> (state_ff == S_JAM && !line_oe)) else $error("cancelled frame continued");

endmodule

//--- tb/sbus_peer_model.sv
`timescale 1ns/1ps
module sbus_peer_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // frame request
  input  wire logic        go,
  input  wire logic [63:0] bits,
  input  wire logic [6:0]  nbits,
  input  wire logic        line,
  // bus side
  output logic             bit_tick,
  output logic             peer_oe,
  output logic             busy,
  output logic [63:0]      seen
);
  logic [6:0] idx;
  logic [1:0] div;
  // ----------------------------------------
  // slot timing, one tick per four cycles
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {bit_tick, peer_oe, busy, seen, idx, div} <= '0;
    end else if (go && !busy) begin
      {busy, idx, div, seen} <= {1'h1, 7'h00, 2'h0, 64'h0};
      peer_oe <= bits[63];
    end else if (busy) begin
      div      <= div + 2'h1;
      bit_tick <= (div == 2'h2);
      if (bit_tick) begin
        seen    <= {seen[62:0], ~line};
        idx     <= idx + 7'h01;
        busy    <= (idx + 7'h01 != nbits);
        peer_oe <= (idx + 7'h01 != nbits) && bits[7'h3E - idx];
      end
    end
  end
endmodule

//--- tb/serial_bus_frame_responder_tb_top.sv
`timescale 1ns/1ps
module serial_bus_frame_responder_tb_top;
  import sbus_pkg::*;
  typedef struct packed {
    logic [9:0] own, s, r;
    ff_mode_t   md;
    logic       jam;
    logic [2:0] pst, ty, st;
    logic       ff;
  } row_t;
  localparam logic [9:0] oc = 10'h0A5;
  localparam logic [9:0] dm = 10'h3FF;
  localparam logic [9:0] rq = 10'h155;
  localparam logic [9:0] xc = 10'h0F0;
  logic clk, reset_n, shared_serial_line_n, line_out, line_oe, bit_tick, sync_err, has_ff, has_sender;
  logic has_receiver, ff_state, tx_ready, tx_wr, tx_sent, rx_release, rx_full, rx_done, own_frame;
  logic frame_busy, frame_done, status_stb, cancel_stb, resend_req, go, peer_oe, pbusy;
  logic [9:0]  own_code;
  logic [2:0]  tx_code, rx_max_code, rx_len, status_val;
  logic [4:0]  tx_addr, rx_addr;
  logic [5:0]  fl;
  logic [7:0]  tx_wdata, rx_rdata;
  logic [63:0] pbits, seen;
  logic [6:0]  nbits;
  ff_mode_t    ff_mode;
  int          num_errors = 0;
  int          cmp_count = 0;
  row_t rows [10] = '{
    '{oc, oc, dm, FF_SIMPLE, 0, 0, 0, 2, 1}, '{oc, dm, oc, FF_SIMPLE, 0, 0, 0, 1, 0},
    '{oc, oc, rq, FF_SEMA, 0, 0, 0, 2, 1},   '{oc, oc, rq, FF_SEMA, 0, 0, 7, 0, 1},
    '{oc, rq, oc, FF_SEMA, 1, 0, 0, 1, 1},   '{oc, rq, oc, FF_SEMA, 0, 0, 0, 1, 0},
    '{oc, dm, oc, FF_TOKEN, 0, 0, 7, 0, 0},  '{oc, oc, dm, FF_TOKEN, 0, 1, 0, 3, 1},
    '{oc, oc, dm, FF_TOKEN, 0, 0, 7, 0, 1},  '{dm, dm, dm, FF_SIMPLE, 0, 0, 0, 0, 1}};
  // ----------------------------------------
  // wired line, clock, pulse catch
  // ----------------------------------------
  assign shared_serial_line_n = (line_oe ? line_out : 1'h1) & ~peer_oe;
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) fl <= go ? 6'h00 : fl | {status_stb, frame_done, cancel_stb, resend_req, tx_sent, rx_done};
  serial_bus_frame_responder u_dut (.clk, .reset_n, .shared_serial_line_n, .line_out, .line_oe, .bit_tick,
    .sync_err, .own_code, .has_ff, .ff_mode, .has_sender, .has_receiver, .ff_state, .tx_ready, .tx_code,
    .tx_wr, .tx_addr, .tx_wdata, .tx_sent, .rx_max_code, .rx_release, .rx_addr, .rx_rdata, .rx_full,
    .rx_len, .rx_done, .own_frame, .frame_busy, .frame_done, .status_val, .status_stb, .cancel_stb,
    .resend_req);
  sbus_peer_model u_peer (.clk, .reset_n, .go, .bits(pbits), .nbits, .line(shared_serial_line_n),
    .bit_tick, .peer_oe, .busy(pbusy), .seen);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task run(input logic [9:0] s, input logic [9:0] r, input logic [37:0] tail, input int n);
    int k;
    @(posedge clk);
    pbits <= {1'h1, 3'h0, s, r, 1'h0, 1'h1, tail};
    nbits <= n[6:0];
    go    <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    k = 0;
    @(negedge clk);
    while (pbusy && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k >= 400) chk("frame_end", 0, 1);
    repeat (3) @(negedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // ----------------------------------------
  // table rows, then hand-written cases
  // ----------------------------------------
  initial begin
    row_t rw;
    logic [37:0] tl;
    int n;
    {reset_n, sync_err, has_sender, has_receiver, tx_ready, tx_wr, rx_release, go} = '0;
    ff_mode = FF_SIMPLE;
    {own_frame, has_ff, own_code, tx_code, rx_max_code} = {2'h3, oc, 3'h1, 3'h1};
    {tx_addr, tx_wdata, rx_addr, pbits, nbits} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    foreach (rows[i]) begin
      rw = rows[i];
      @(posedge clk);
      own_code <= rw.own;
      ff_mode  <= rw.md;
      tl = (rw.ty == 3'h7) ? {3'h0, rw.jam, 34'h0} : {3'h0, rw.pst, rw.jam, 31'h0};
      n = (rw.ty == 3'h7) ? 30 : (rw.jam ? 49 : 33);
      run(rw.s, rw.r, tl, n);
      chk("type", 3'(seen >> (n - 29)), rw.ty);
      if (rw.ty != 3'h7) chk("status", 3'(seen >> (n - 32)), rw.st);
      if (rw.ty != 3'h7 && !rw.jam) chk("status_val", status_val, rw.st);
      chk("ff_state", ff_state, rw.ff);
      chk("cancel", fl[3], rw.ty == 3'h7);
      chk("resend", fl[2], rw.jam);
      chk("done", fl[4], 1);
      chk("status_stb", fl[5], rw.ty != 3'h7 && !rw.jam);
    end
    @(posedge clk);
    {has_ff, has_sender, own_code, tx_ready, tx_wr, tx_wdata} <= {2'h1, oc, 2'h3, 8'hA5};
    @(posedge clk);
    tx_wr <= 1'h0;
    run(oc, xc, {3'h0, 8'h00, 3'h1, 1'h0, 23'h0}, 41);
    chk("tx_type", seen[14:12], 3'h1);
    chk("tx_data", seen[11:4], 8'hA5);
    chk("tx_status", seen[3:1], 3'h3);
    chk("status_val", status_val, 3'h3);
    chk("tx_sent", fl[1], 1);
    run(oc, xc, {3'h7, 1'h0, 34'h0}, 30);
    chk("tx_sent", fl[1], 0);
    @(posedge clk);
    tx_ready <= 1'h0;
    run(oc, xc, {3'h0, 1'h0, 34'h0}, 30);
    chk("nr_type", seen[3:1], 3'h7);
    @(posedge clk);
    {has_sender, has_receiver} <= 2'h1;
    run(xc, oc, {3'h1, 8'h3C, 3'h2, 1'h0, 23'h0}, 41);
    chk("rx_status", seen[3:1], 3'h3);
    chk("rx_data", rx_rdata, 8'h3C);
    chk("rx_len", {rx_full, rx_len, fl[0]}, 5'h13);
    run(xc, oc, {3'h1, 1'h0, 34'h0}, 30);
    chk("full_type", seen[3:1], 3'h7);
    @(posedge clk);
    rx_release <= 1'h1;
    @(posedge clk);
    rx_release <= 1'h0;
    run(xc, oc, {3'h2, 16'h1234, 3'h2, 1'h0, 15'h0}, 49);
    chk("long_status", seen[3:1], 3'h7);
    @(posedge clk);
    sync_err <= 1'h1;
    @(posedge clk);
    sync_err <= 1'h0;
    run(10'h000, 10'h000, 38'h0, 42);
    chk("jam_run", seen[41:26], 16'hFFFF);
    chk("resync", {fl[4], fl[2]}, 2'h3);
    @(posedge clk);
    reset_n <= 1'h0;
    @(negedge clk);
    chk("reset", {ff_state, line_oe, frame_busy}, 3'h0);
    end_sim();
  end
endmodule
